// file: uss_pkg.sv
package uss_pkg;
  // Operating modes on the mode select inputs
  localparam logic [1:0] USS_OPMODE_NORMAL = 2'h0;
  localparam logic [1:0] USS_OPMODE_NOENC = 2'h2;
  // Line state codes, {dm, dp}
  localparam logic [1:0] USS_LS_SE0 = 2'h0;
  localparam logic [1:0] USS_LS_J = 2'h1;
  localparam logic [1:0] USS_LS_K = 2'h2;
  // Reset values
  localparam logic [1:0] USS_LS_RST = 2'h0;
  localparam logic USS_TERM_FS_RST = 1'h1;
  // Timing
  localparam int unsigned USS_CLK_MHZ = 125;
  localparam int unsigned USS_OSC_STAB_US = 5000;
  localparam int unsigned USS_OSC_STAB_CYC = USS_OSC_STAB_US * USS_CLK_MHZ;
  localparam int USS_STAB_W = 20;
  // Data pattern that forms the resume K
  localparam logic [7:0] USS_DATA_ZERO = 8'h00;
endpackage : uss_pkg

// file: uss_osc_if.sv
`timescale 1ns/1ps
`default_nettype none
interface uss_osc_if;
  logic suspend_n;
  logic osc_en;
  logic clk_usable;
  modport core (output suspend_n, input osc_en, input clk_usable);
  modport osc (input suspend_n, output osc_en, output clk_usable);
endinterface : uss_osc_if
`default_nettype wire

// file: uss_osc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module uss_osc_ctrl
  import uss_pkg::*;
#(
  parameter int unsigned STAB_CYC = USS_OSC_STAB_CYC
) (
  input wire logic i_clk,
  input wire logic i_srst,
  uss_osc_if.osc osc
);
  localparam logic [USS_STAB_W-1:0] STAB_LAST =
    USS_STAB_W'(STAB_CYC - 1);

  logic [USS_STAB_W-1:0] stab_cnt;

  // ==========================================
  // Oscillator power follows suspend control
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      osc.osc_en <= 1'b0;
    end else begin
      osc.osc_en <= osc.suspend_n; // RL3 RL10
    end
  end

  // ==========================================
  // Stabilisation wait before the clock counts as usable
  // Any drop of power restarts the wait from zero
  always_ff @(posedge i_clk) begin
    if (i_srst || !osc.osc_en || !osc.suspend_n) begin
      stab_cnt <= '0;
      osc.clk_usable <= 1'b0;
    end else if (stab_cnt != STAB_LAST) begin
      stab_cnt <= stab_cnt + USS_STAB_W'(1);
    end else begin
      osc.clk_usable <= 1'b1; // RL3 RL10
    end
  end

  AST_OSC_OFF: assert property (@(posedge i_clk) disable iff (i_srst)
    !osc.suspend_n |=> !osc.clk_usable && !osc.osc_en) // RL3
    else $error("clock usable while suspended");

  AST_STAB_WAIT: assert property (@(posedge i_clk) disable iff (i_srst)
    $rose(osc.osc_en) |-> !osc.clk_usable [*8]) // RL10
    else $error("clock usable without stabilisation wait");
endmodule : uss_osc_ctrl
`default_nettype wire

// file: uss_core.sv
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// RL1 - Link waits 5 ms of idle bus before remote wake-up resume.
// RL2 - Link drives resume within 10 ms of its internal wake event.
// RL3 - Suspend release powers the oscillator; clock usable after stabilising.
// RL4 - Resume K: no-encode mode, FS selected, TX valid, zero data, 1 ms.
// RL5 - Link releases the resume K between 1.0 ms and 15 ms.
// RL6 - Downstream port ends resume with SE0 20 ms after K began.
// RL7 - Prior HS device restores HS within 1.33 us after activity stops.
// RL8 - Prior FS device keeps termination and transceiver selects high.
// RL9 - Resume detection in FS; line state J, K, then short SE0.
// RL10 - Host resume K lasts 20 ms; suspend release powers the oscillator.
// RL11 - Link leaves suspend on the J to K change, not on SE0.
// RL12 - Link restores prior speed mode within 1.25 us of SE0.
// RL13 - FS terminations stay enabled while FS termination is selected.
// RL14 - Prior HS device switches terminations before the SE0 ends.
// RL15 - Link selects FS mode within 100 ms of bus power valid.
// RL16 - DP pull-up is enabled whenever FS termination is selected.
// RL17 - After attach link watches for SE0 reset after debounce.
// RL18 - Debounce before HS handshake exceeds 100 ms after attach.
// RL19 - Line state is unfiltered; the link checks state persistence. Here the core drops one-cycle glitches by stage agreement.
// RL20 - Link times 1 ms as 66000 clock output cycles.
// RL21 - Link records HS or FS mode at suspend entry.
// RL22 - Link counts no time while suspended; counters restart after.
module uss_core
  import uss_pkg::*;
#(
  parameter int unsigned OSC_STAB_CYC = USS_OSC_STAB_CYC
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_suspend_n,
  input wire logic [1:0] i_opmode,
  input wire logic i_termselect,
  input wire logic i_xcvrselect,
  input wire logic i_txvalid,
  input wire logic [7:0] i_data,
  input wire logic i_dp,
  input wire logic i_dm,
  output logic [1:0] o_linestate,
  output logic o_osc_en,
  output logic o_clk_usable,
  output logic o_dp_pullup,
  output logic o_hs_term,
  output logic o_dp,
  output logic o_dp_oe,
  output logic o_dm,
  output logic o_dm_oe
);
  uss_osc_if oif ();

  logic [1:0] line_s1;
  logic [1:0] line_s2;
  logic [1:0] line_s3;
  logic next_drive_k;

  // ==========================================
  // Oscillator sequencing
  assign oif.suspend_n = i_suspend_n;

  uss_osc_ctrl #(
    .STAB_CYC(OSC_STAB_CYC)
  ) u_osc (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .osc(oif)
  );

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_osc_en <= 1'b0;
      o_clk_usable <= 1'b0;
    end else begin
      o_osc_en <= oif.osc_en; // RL3
      // Gated again by suspend so no stale clock shows one cycle late
      o_clk_usable <= oif.clk_usable && i_suspend_n; // RL10
    end
  end

  // ==========================================
  // Line state: three-stage sync, change taken when stages 2 and 3 agree
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      line_s1 <= USS_LS_RST;
      line_s2 <= USS_LS_RST;
      line_s3 <= USS_LS_RST;
    end else begin
      line_s1 <= {i_dm, i_dp};
      line_s2 <= line_s1;
      line_s3 <= line_s2;
    end
  end

  // Stage 2/3 agreement drops one-cycle glitches; longer persistence is the link's job
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_linestate <= USS_LS_RST;
    end else if (line_s2 == line_s3) begin
      o_linestate <= line_s3;
    end
  end

  // ==========================================
  // Terminations and attach pull-up
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_dp_pullup <= USS_TERM_FS_RST;
      o_hs_term <= ~USS_TERM_FS_RST;
    end else begin
      o_dp_pullup <= i_termselect; // RL16 RL13
      o_hs_term <= ~i_termselect; // RL13
    end
  end

  AST_PULLUP_FS: assert property (@(posedge i_clk) disable iff (i_srst)
    i_termselect |=> o_dp_pullup && !o_hs_term) // RL16
    else $error("pull-up off while FS termination selected");

  AST_FS_TERM_HELD: assert property (@(posedge i_clk) disable iff (i_srst)
    i_termselect [*3] |=> o_dp_pullup && $stable(o_dp_pullup)) // RL13
    else $error("FS termination dropped while selected");

  AST_HS_TERM_OFF: assert property (@(posedge i_clk) disable iff (i_srst)
    !i_termselect |=> o_hs_term && !o_dp_pullup) // RL16
    else $error("pull-up left on while HS termination selected");

  AST_LS_HOLD: assert property (@(posedge i_clk) disable iff (i_srst)
    (line_s2 != line_s3) |=> $stable(o_linestate)) // RL9
    else $error("line state moved while sync stages disagree");

  AST_LS_FOLLOW: assert property (@(posedge i_clk) disable iff (i_srst)
    (line_s2 == line_s3) |=> (o_linestate == $past(line_s3))) // RL9
    else $error("line state did not follow settled pins");

  // ==========================================
  // Resume K driver: raw mode, FS path, zero data, powered clock
  // Suspend gates the drive at once; the usable flag lags one cycle
  always_comb begin
    next_drive_k = i_txvalid && (i_opmode == USS_OPMODE_NOENC) &&
      i_xcvrselect && i_termselect && (i_data == USS_DATA_ZERO) &&
      oif.clk_usable && i_suspend_n;
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_dp <= 1'b0;
      o_dm <= 1'b0;
      o_dp_oe <= 1'b0;
      o_dm_oe <= 1'b0;
    end else begin
      o_dp <= 1'b0;
      o_dm <= next_drive_k;
      o_dp_oe <= next_drive_k;
      o_dm_oe <= next_drive_k;
    end
  end

  AST_K_ONLY_AWAKE: assert property (@(posedge i_clk) disable iff (i_srst)
    !i_suspend_n |=> ##1 !o_dm_oe && !o_clk_usable) // RL3
    else $error("line driven or clock usable in suspend");

  AST_SUSP_NO_DRIVE: assert property (@(posedge i_clk) disable iff (i_srst)
    !i_suspend_n |=> !o_dm_oe && !o_dp_oe) // RL3
    else $error("line driven in the cycle after suspend");

  AST_OSC_FOLLOW: assert property (@(posedge i_clk) disable iff (i_srst)
    i_suspend_n |-> ##2 o_osc_en) // RL3
    else $error("oscillator not powered after suspend release");

  AST_DRIVE_NEEDS_ZERO: assert property (@(posedge i_clk) disable iff (i_srst)
    (i_data != USS_DATA_ZERO) |=> !o_dm_oe && !o_dp_oe) // RL10
    else $error("line driven with nonzero data");

  // Both lines always enabled together; dp held low during the K
  AST_OE_PAIR: assert property (@(posedge i_clk) disable iff (i_srst)
    o_dp_oe |-> o_dm_oe && o_dm && !o_dp) // RL10
    else $error("K drive pattern broken");
endmodule : uss_core
`default_nettype wire

// file: uss_link_model.sv
`timescale 1ns/1ps
`default_nettype none
module uss_link_model
  import uss_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_awake,
  input wire logic i_resume,
  input wire logic i_fs,
  input wire logic i_bad,
  output logic o_suspend_n,
  output logic [1:0] o_opmode,
  output logic o_fs_sel,
  output logic o_txvalid,
  output logic [7:0] o_data
);
  // ==========================================
  // Link side, one register stage
  always_ff @(posedge i_clk) begin
    o_suspend_n <= i_awake;
    o_fs_sel <= i_fs;
    o_opmode <= i_resume ? USS_OPMODE_NOENC : USS_OPMODE_NORMAL;
    o_txvalid <= i_resume;
    // Nonzero data only when a refusal is wanted
    o_data <= i_bad ? 8'h01 : USS_DATA_ZERO;
  end
endmodule : uss_link_model
`default_nettype wire

// file: test_usb_suspend_resume_attach_seq.sv
`timescale 1ns/1ps
`default_nettype none
module test_usb_suspend_resume_attach_seq;
  import uss_pkg::*;
  logic i_clk = 1'h0, i_srst = 1'h1, awake = 1'h0, res = 1'h0, fs = 1'h1;
  logic bad = 1'h0, dp = 1'h1, dm = 1'h0, sn, fsel, txv, pu, hst, ce, osc;
  logic dmo, dmoe, dpo, dpoe;
  logic [1:0] opm, ls;
  logic [7:0] dat;
  int fails = 0, n_tests = 0, cyc = 0, k;
  // Rows of {fs, dm, dp}
  logic [2:0] rows [4] = '{3'h5, 3'h6, 3'h0, 3'h5};

  uss_link_model u_link (.i_clk(i_clk), .i_awake(awake), .i_resume(res),
    .i_fs(fs), .i_bad(bad), .o_suspend_n(sn), .o_opmode(opm),
    .o_fs_sel(fsel), .o_txvalid(txv), .o_data(dat));

  uss_core #(.OSC_STAB_CYC(16)) u_dut (.i_clk(i_clk), .i_srst(i_srst),
    .i_suspend_n(sn), .i_opmode(opm), .i_termselect(fsel),
    .i_xcvrselect(fsel), .i_txvalid(txv), .i_data(dat), .i_dp(dp),
    .i_dm(dm), .o_linestate(ls), .o_osc_en(osc), .o_clk_usable(ce),
    .o_dp_pullup(pu), .o_hs_term(hst), .o_dp(dpo), .o_dp_oe(dpoe),
    .o_dm(dmo), .o_dm_oe(dmoe));

  initial begin
    forever #4 i_clk = ~i_clk;
  end

  // ==========================================
  // Helpers
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic step(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : step

  task automatic complete_run;
    $display("fails=%0d n_tests=%0d", fails, n_tests);
    if (fails == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run

  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 1000) begin
      fails++;
      complete_run;
    end
  end

  // ==========================================
  // Scenarios
  initial begin
    step(20);
    check({ls, ce, osc, pu, hst, dmoe, dpoe}, {USS_LS_RST, 4'h2, 2'h0});
    i_srst = 1'h0;
    foreach (rows[i]) begin
      {fs, dm, dp} = rows[i];
      step(5);
      check({5'h0, ls, pu}, {5'h0, rows[i][1:0], rows[i][2]});
      check({7'h0, hst}, {7'h0, ~rows[i][2]});
    end
    awake = 1'h1;
    for (k = 0; k < 40 && ce !== 1'h1; k++) begin
      step(1);
    end
    // Taken one edge after the model, then 16 + 2..3 edges
    check({7'h0, k >= 17 && k <= 22}, 8'h1);
    check({7'h0, osc}, 8'h1);
    res = 1'h1;
    step(3);
    check({4'h0, dmo, dmoe, dpoe, dpo}, 8'h0e);
    bad = 1'h1;
    step(3);
    check({6'h0, dmoe, dpoe}, 8'h0);
    bad = 1'h0;
    awake = 1'h0;
    step(4);
    check({5'h0, ce, osc, dmoe}, 8'h0);
    awake = 1'h1;
    step(12);
    // Count restarts in full after a suspend
    check({7'h0, ce}, 8'h0);
    res = 1'h0;
    complete_run;
  end
endmodule : test_usb_suspend_resume_attach_seq
`default_nettype wire
